// ---- cpu_model.sv ----
/*
 * Processor model issuing one instruction at a time.
 * Assumes answers are registered at the taking edge and read just after it.
 */
`timescale 1ns/1ps
module cpu_model (
	// Clock.
	input wire logic mclk_i,
	// Instruction port.
	output logic iot_valid_o,
	output logic [17:0] iot_code_o,
	output logic [17:0] ac_o,
	input wire logic skip_i,
	input wire logic ac_or_valid_i,
	input wire logic [17:0] ac_or_i
);
	logic sk;
	logic acv;
	logic [17:0] acc;
	// Idle bus at time zero.
	initial begin
		iot_valid_o = 1'b0;
		iot_code_o = 18'h00000;
		ac_o = 18'h00000;
	end
	// One instruction word, possibly microcoded; the answer is ORed in.
	task automatic iot(input logic [17:0] code, input logic [17:0] ac);
		@(posedge mclk_i);
		#1;
		iot_valid_o = 1'b1;
		iot_code_o = code;
		ac_o = ac;
		@(posedge mclk_i);
		#1;
		iot_valid_o = 1'b0;
		ac_o = ~ac; // A released bus shows junk, not the old value.
		sk = skip_i;
		acv = ac_or_valid_i;
		acc = ac | (ac_or_valid_i ? ac_or_i : 18'h00000);
	endtask : iot
endmodule : cpu_model

// ---- disk_control_status_iot_bench.sv ----
/*
 * Self-checking bench for the disk control.
 * Assumes the checker is bound by its own file and a 20-cycle timeout.
 */
`timescale 1ns/1ps
`include "disk_ctl_regs.svh"
module disk_control_status_iot_bench;
	logic mclk_i = 1'b0;
	logic reset_i = 1'b1;
	logic [6:0] ev = 7'h00;
	logic wg;
	logic prot = 1'b0;
	logic [7:0] present = 8'hFF;
	logic iv;
	logic [17:0] code;
	logic [17:0] ac;
	logic skip;
	logic acv;
	logic [17:0] acor;
	logic flag;
	logic irq;
	logic [10:0] st;
	logic req;
	logic [1:0] fn;
	logic frz;
	logic [17:0] ptr;
	logic [2:0] drv;
	int error_cnt = 0;
	int comparisons = 0;
	// Free-running 25 MHz clock.
	always #20 mclk_i = ~mclk_i;
	cpu_model u_cpu (.mclk_i(mclk_i), .iot_valid_o(iv), .iot_code_o(code), .ac_o(ac),
		.skip_i(skip), .ac_or_valid_i(acv), .ac_or_i(acor));
	disk_ctl #(.MXF_TIMEOUT_CYCLES(20)) u_dut (.mclk_i(mclk_i), .reset_i(reset_i),
		.iot_valid_i(iv), .iot_code_i(code), .ac_i(ac), .skip_o(skip),
		.ac_or_valid_o(acv), .ac_or_o(acor), .disk_flag_o(flag), .interrupt_req_o(irq),
		.status_o(st), .word_slot_i(ev[0]), .xfer_ack_i(ev[1]), .job_done_i(ev[2]),
		.addr_parity_evt_i(ev[4]), .timing_fault_evt_i(ev[3]), .word_parity_bad_i(ev[5]),
		.compare_mismatch_evt_i(ev[6]), .protect_region_i(prot), .drive_present_i(present),
		.xfer_req_o(req), .function_o(fn), .freeze_o(frz), .write_gate_o(wg),
		.track_word_pointer_o(ptr), .drive_select_o(drv));
	task automatic chk(input string n, input logic [17:0] e, input logic [17:0] g);
		comparisons++;
		if (g !== e) begin
			error_cnt++;
			$display("[FAIL] %s expected %h seen %h", n, e, g);
		end
	endtask : chk
	// One-cycle disk event pulse; the design sees it at the following edge.
	task automatic pulse(input int i);
		@(posedge mclk_i);
		#1;
		ev[i] = 1'b1;
		@(posedge mclk_i);
		#1;
		ev = 7'h00;
	endtask : pulse
	// Several disk events in one cycle, given as a mask.
	task automatic pulse_mask(input logic [6:0] m);
		@(posedge mclk_i);
		#1;
		ev = m;
		@(posedge mclk_i);
		#1;
		ev = 7'h00;
	endtask : pulse_mask
	task automatic tick();
		@(posedge mclk_i);
		#1;
	endtask : tick
	task automatic report_and_stop();
		$display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
		if (error_cnt == 0 && comparisons > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask : report_and_stop
	// Pointer and drive number load and read back.
	task automatic t_regs();
		chk("status", 18'h0, {7'h0, st});
		u_cpu.iot(18'h38E14, 18'h2A5A5);
		u_cpu.iot(18'h38E12, 18'h00000);
		chk("pointer", 18'h2A5A5, u_cpu.acc);
		chk("pointer pin", 18'h2A5A5, ptr);
		u_cpu.iot(18'h38E34, 18'h00005);
		u_cpu.iot(18'h38E32, 18'h00000);
		chk("drive", 18'h5, u_cpu.acc);
		chk("drive pin", 18'h5, {15'h0, drv});
	endtask : t_regs
	// Microcoded start of a read, one word, completion and skip.
	task automatic t_read();
		u_cpu.iot(18'h38E27, 18'h00003);
		chk("read fn", 18'h1, {16'h0, fn});
		pulse(0);
		chk("request", 18'h1, {17'h0, req});
		chk("advance", 18'h2A5A6, ptr);
		pulse(1);
		pulse(2);
		tick();
		chk("complete", 18'h1, {17'h0, st[`ST_XFC]});
		chk("irq", 18'h1, {17'h0, irq});
		chk("halted", 18'h0, {16'h0, fn});
		u_cpu.iot(18'h38E01, 18'h00000);
		chk("skip", 18'h1, {17'h0, u_cpu.sk});
		u_cpu.iot(18'h38E21, 18'h00000);
		u_cpu.iot(18'h38E24, 18'h00000);
		chk("empty exec", 18'h1, {17'h0, st[`ST_PGE]});
		chk("irq off", 18'h0, {17'h0, irq});
	endtask : t_read
	// Write into a protected region.
	task automatic t_protect();
		u_cpu.iot(18'h38E11, 18'h00000);
		chk("cleared", 18'h0, {7'h0, st});
		prot = 1'b1;
		u_cpu.iot(18'h38E26, 18'h00004);
		chk("write fn", 18'h2, {16'h0, fn});
		chk("write gate", 18'h1, {17'h0, wg});
		pulse(0);
		chk("no request", 18'h0, {17'h0, req});
		tick();
		chk("lockout", 18'h41, {7'h0, st});
		chk("gate shut", 18'h0, {17'h0, wg});
		prot = 1'b0;
	endtask : t_protect
	// Selecting an absent drive, then a late channel and a timeout.
	task automatic t_drive_mxf();
		u_cpu.iot(18'h38E11, 18'h00000);
		present = 8'hFE;
		u_cpu.iot(18'h38E34, 18'h00000);
		tick();
		chk("absent", 18'h1, {17'h0, st[`ST_NED]});
		present = 8'hFF;
		u_cpu.iot(18'h38E11, 18'h00000);
		u_cpu.iot(18'h38E34, 18'h00001);
		u_cpu.iot(18'h38E27, 18'h00002);
		pulse(0);
		pulse(0);
		tick();
		chk("late warn", 18'h100, {7'h0, st});
		chk("no flag", 18'h0, {17'h0, flag});
		repeat (25) tick();
		chk("missed", 18'h1, {17'h0, st[`ST_MXF]});
	endtask : t_drive_mxf
	// Disk errors: idle parity with no job, then in running jobs first error, word parity, check mismatch.
	task automatic t_errors();
		u_cpu.iot(18'h38E11, 18'h00000);
		pulse(4);
		tick();
		chk("idle parity", 18'h0, {7'h0, st});
		u_cpu.iot(18'h38E27, 18'h00002);
		pulse_mask(7'h30);
		tick();
		chk("first error", 18'h5, {7'h0, st});
		chk("parity freeze", 18'h1, {17'h0, frz});
		u_cpu.iot(18'h38E11, 18'h00000);
		u_cpu.iot(18'h38E27, 18'h00002);
		pulse_mask(7'h21);
		chk("bad word moves", 18'h1, {17'h0, req});
		tick();
		chk("word parity", 18'h21, {7'h0, st});
		chk("parity halt", 18'h0, {16'h0, fn});
		u_cpu.iot(18'h38E11, 18'h00000);
		u_cpu.iot(18'h38E27, 18'h00006);
		pulse(0);
		chk("check no advance", 18'h0, ptr);
		pulse(1);
		chk("check advance", 18'h1, ptr);
		pulse(6);
		tick();
		chk("mismatch", 18'h11, {7'h0, st});
		chk("check halt", 18'h0, {16'h0, fn});
		chk("one past", 18'h1, ptr);
	endtask : t_errors
	// Read roll-over past the last drive sets overrun and the absent-drive error.
	task automatic t_overrun();
		u_cpu.iot(18'h38E11, 18'h00000);
		u_cpu.iot(18'h38E34, 18'h00007);
		u_cpu.iot(18'h38E14, 18'h3FFFF);
		u_cpu.iot(18'h38E27, 18'h00002);
		pulse(0);
		chk("roll pointer", 18'h0, ptr);
		chk("roll drive", 18'h0, {15'h0, drv});
		tick();
		chk("overrun err", 18'h1, {17'h0, st[`ST_NED]});
		u_cpu.iot(18'h38E32, 18'h00000);
		chk("overrun bit", 18'h8, u_cpu.acc);
	endtask : t_overrun
	// Timing fault freezes; only the clear is obeyed.
	task automatic t_freeze();
		u_cpu.iot(18'h38E11, 18'h00000);
		pulse(3);
		tick();
		chk("frozen", 18'h1, {17'h0, frz});
		u_cpu.iot(18'h38E12, 18'h00000);
		chk("deaf", 18'h0, {17'h0, u_cpu.acv});
		u_cpu.iot(18'h38E11, 18'h00000);
		chk("thawed", 18'h0, {17'h0, frz});
	endtask : t_freeze
	// Watchdog sized well beyond the whole sequence.
	initial begin
		repeat (3000) @(posedge mclk_i);
		error_cnt++;
		report_and_stop();
	end
	// Reset for ten cycles, then the scenarios in order.
	initial begin
		repeat (10) @(posedge mclk_i);
		#1;
		reset_i = 1'b0;
		t_regs();
		t_read();
		t_protect();
		t_drive_mxf();
		t_errors();
		t_overrun();
		t_freeze();
		report_and_stop();
	end
endmodule : disk_control_status_iot_bench

// ---- disk_ctl.sv ----
/*
 * Disk control status register and instruction decode.
 * Assumes the processor presents one instruction per iot_valid_i pulse with
 * the accumulator, and ORs ac_or_o onto its accumulator when ac_or_valid_o.
 * Disk timing, address matching and channel events arrive as one-cycle pulses.
 */
`timescale 1ns/1ps
`include "disk_ctl_regs.svh"
module disk_ctl import disk_ctl_pkg::*; #(
	parameter int MXF_TIMEOUT_CYCLES = `MXF_TIMEOUT_MS * `MCLK_KHZ,
	parameter int NUM_DRIVES = 8
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_i,
	// Processor instruction port.
	input wire logic iot_valid_i,
	input wire logic [17:0] iot_code_i,
	input wire logic [17:0] ac_i,
	output logic skip_o,
	output logic ac_or_valid_o,
	output logic [17:0] ac_or_o,
	// Interrupt and flag reporting.
	output logic disk_flag_o,
	output logic interrupt_req_o,
	output logic [10:0] status_o,
	// Disk side events.
	input wire logic word_slot_i,
	input wire logic xfer_ack_i,
	input wire logic job_done_i,
	input wire logic addr_parity_evt_i,
	input wire logic timing_fault_evt_i,
	input wire logic word_parity_bad_i,
	input wire logic compare_mismatch_evt_i,
	input wire logic protect_region_i,
	input wire logic [NUM_DRIVES-1:0] drive_present_i,
	// Disk side controls.
	output logic xfer_req_o,
	output logic [1:0] function_o,
	output logic freeze_o,
	output logic write_gate_o,
	output logic [17:0] track_word_pointer_o,
	output logic [2:0] drive_select_o
);
	typedef struct packed {
		logic [2:0] function_reg;
		fn_e active;
		xfer_e xfer;
		logic [17:0] track_word_pointer;
		logic [2:0] drive;
		logic overrun;
		logic [10:0] status;
		logic first_err_seen;
		logic freeze;
		logic disk_flag;
		logic irq;
		logic skip;
		logic rd_valid;
		logic [17:0] rd_data;
		logic xfer_req;
		logic write_gate;
	} ctl_s;

	ctl_s s;
	ctl_s next_s;
	logic t_start;
	logic t_stop;

	mxf_timer_if tif ();

	mxf_timer #(
		.CYCLES(MXF_TIMEOUT_CYCLES)
	) u_timer (
		.mclk_i(mclk_i),
		.reset_i(reset_i),
		.tif(tif)
	);

	assign tif.start = t_start;
	assign tif.stop = t_stop;

	// True when the numbered drive is wired in.
	function automatic logic present(input logic [2:0] n, input logic [NUM_DRIVES-1:0] map);
		logic r;
		r = 1'b0;
		if (32'(n) < NUM_DRIVES) begin
			r = map[n];
		end
		return r;
	endfunction : present

	// Next-state logic: clear, then instructions, then disk events, then flag posting.
	always_comb begin
		logic is_iot;
		logic [2:0] sub;
		logic [2:0] pls;
		logic running;
		logic advance;
		logic [11:0] word_sum;
		logic [7:0] track_sum;
		logic [3:0] drive_sum;
		logic [10:0] sets;
		logic [10:0] new_bits;
		logic [2:0] fr_work;
		is_iot = iot_valid_i && (iot_code_i[17:6] == `IOT_GROUP);
		sub = iot_code_i[5:3];
		pls = iot_code_i[2:0];
		running = (s.active != FN_NONE) && !s.freeze;
		advance = 1'b0;
		word_sum = '0;
		track_sum = '0;
		drive_sum = '0;
		sets = '0;
		new_bits = '0;
		fr_work = s.function_reg;
		t_start = 1'b0;
		t_stop = 1'b0;
		next_s = s;
		next_s.skip = 1'b0;
		next_s.rd_valid = 1'b0;
		next_s.rd_data = '0;
		next_s.xfer_req = 1'b0;

		// Clear control is the one instruction a frozen control obeys.
		if (is_iot && sub == `SUB_POINTER && pls == 3'h1) begin
			next_s = '0;
			t_stop = 1'b1;
		end else if (is_iot && !s.freeze) begin
			unique case (sub)
				`SUB_FLAG: begin
					if (pls[`PULSE_1]) begin
						next_s.skip = s.disk_flag;
					end
				end
				`SUB_POINTER: begin
					if (pls[`PULSE_2]) begin
						next_s.rd_valid = 1'b1;
						next_s.rd_data = s.track_word_pointer;
					end
					if (pls[`PULSE_4]) begin
						// Reloading the pointer under a running job would corrupt it.
						if (s.active != FN_NONE) begin
							sets[`ST_PGE] = 1'b1;
						end else begin
							next_s.track_word_pointer = ac_i;
						end
					end
				end
				`SUB_DRIVE: begin
					if (pls[`PULSE_2]) begin
						next_s.rd_valid = 1'b1;
						next_s.rd_data = {14'h0000, s.overrun, s.drive};
					end
					if (pls[`PULSE_4]) begin
						if (s.active != FN_NONE) begin
							sets[`ST_PGE] = 1'b1;
						end else begin
							next_s.drive = ac_i[2:0];
							next_s.overrun = 1'b0;
							if (!present(ac_i[2:0], drive_present_i)) begin
								sets[`ST_NED] = 1'b1;
							end
						end
					end
				end
				`SUB_FUNCTION: begin
					// Microcoded pulses apply in order: clear, XOR, execute.
					if (pls[`PULSE_1]) begin
						fr_work = 3'h0;
					end
					if (pls[`PULSE_2]) begin
						fr_work = fr_work ^ ac_i[2:0];
					end
					next_s.function_reg = fr_work;
					if (pls[`PULSE_4]) begin
						if (fr_work[2:1] == FN_NONE) begin
							sets[`ST_PGE] = 1'b1;
						end else begin
							next_s.active = fn_e'(fr_work[2:1]);
							next_s.first_err_seen = 1'b0;
							if (!present(s.drive, drive_present_i)) begin
								sets[`ST_NED] = 1'b1;
							end
						end
					end
				end
				default: begin
					// Sub-devices not decoded here leave the control untouched.
				end
			endcase
		end

		// Hardware timing faults freeze the control whatever it is doing.
		if (timing_fault_evt_i && !s.freeze) begin
			sets[`ST_HDW] = 1'b1;
			next_s.freeze = 1'b1;
		end

		// Disk events count only while a function is executing.
		// The first-error latch is read from the next state, so an earlier error suppresses a
		// later one in the same cycle.
		if (running) begin
			if (addr_parity_evt_i && !next_s.first_err_seen) begin
				sets[`ST_APE] = 1'b1;
				next_s.first_err_seen = 1'b1;
				next_s.freeze = 1'b1;
			end
			if (word_parity_bad_i && s.active == FN_READ && !next_s.first_err_seen) begin
				sets[`ST_DPE] = 1'b1;
				next_s.first_err_seen = 1'b1;
			end
			if (compare_mismatch_evt_i && s.active == FN_CHECK) begin
				sets[`ST_WCE] = 1'b1;
			end
			if (word_slot_i) begin
				if (s.active == FN_WRITE && protect_region_i) begin
					// Only writing is refused; read and check pass over protected areas.
					if (!next_s.first_err_seen) begin
						sets[`ST_WLO] = 1'b1;
						next_s.first_err_seen = 1'b1;
					end
				end else if (s.xfer == XF_PENDING) begin
					sets[`ST_DCH] = 1'b1;
				end else begin
					next_s.xfer_req = 1'b1;
					next_s.xfer = XF_PENDING;
					t_start = 1'b1;
					advance = (s.active == FN_READ);
				end
			end
			if (xfer_ack_i && s.xfer == XF_PENDING) begin
				next_s.xfer = XF_IDLE;
				t_stop = 1'b1;
				advance = (s.active != FN_READ);
			end
			if (tif.expired && s.xfer == XF_PENDING) begin
				sets[`ST_MXF] = 1'b1;
			end
			if (job_done_i) begin
				sets[`ST_XFC] = 1'b1;
			end
		end

		// Word, then track, then drive roll over in sequence.
		if (advance) begin
			word_sum = {1'b0, s.track_word_pointer[`WORD_MSB:`WORD_LSB]} + 12'h001;
			track_sum = {1'b0, s.track_word_pointer[`TRACK_MSB:`TRACK_LSB]} + {7'h00, word_sum[11]};
			drive_sum = {1'b0, s.drive} + {3'h0, track_sum[7]};
			next_s.track_word_pointer = {track_sum[6:0], word_sum[10:0]};
			next_s.drive = drive_sum[2:0];
			if (drive_sum[3]) begin
				next_s.overrun = 1'b1;
				sets[`ST_NED] = 1'b1;
			end else if (track_sum[7] && !present(drive_sum[2:0], drive_present_i)) begin
				sets[`ST_NED] = 1'b1;
			end
		end

		// Sets are ORed in after any clear so a same-cycle event survives.
		new_bits = sets & ~next_s.status;
		next_s.status = next_s.status | sets;
		next_s.status[`ST_ERR] = |next_s.status[`ST_NED:`ST_HDW];
		next_s.disk_flag = next_s.status[`ST_ERR] | next_s.status[`ST_XFC];
		next_s.irq = next_s.disk_flag & next_s.function_reg[0];

		// A newly posted flag halts execution but keeps the loaded function.
		if (|new_bits[`ST_NED:`ST_HDW] || new_bits[`ST_XFC]) begin
			next_s.active = FN_NONE;
			next_s.xfer = XF_IDLE;
			t_stop = 1'b1;
			t_start = 1'b0;
		end
		next_s.write_gate = (next_s.active == FN_WRITE) && !next_s.freeze;
	end

	// State register; system reset lands here at zero, clear control at zero plus any same-cycle event.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	// Every output is a field of the state register.
	assign skip_o = s.skip;
	assign ac_or_valid_o = s.rd_valid;
	assign ac_or_o = s.rd_data;
	assign disk_flag_o = s.disk_flag;
	assign interrupt_req_o = s.irq;
	assign status_o = s.status;
	assign xfer_req_o = s.xfer_req;
	assign function_o = s.active;
	assign freeze_o = s.freeze;
	assign write_gate_o = s.write_gate;
	assign track_word_pointer_o = s.track_word_pointer;
	assign drive_select_o = s.drive;
endmodule : disk_ctl

// ---- disk_ctl_checker.sv ----
/*
 * Concurrent checks on the disk control ports.
 * Assumes one clock and a synchronous active-high reset.
 */
`timescale 1ns/1ps
module disk_ctl_checker (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_i,
	// Watched ports.
	input wire logic iot_valid_i,
	input wire logic [17:0] iot_code_i,
	input wire logic timing_fault_evt_i,
	input wire logic addr_parity_evt_i,
	input wire logic skip_o,
	input wire logic ac_or_valid_o,
	input wire logic disk_flag_o,
	input wire logic [10:0] status_o,
	input wire logic [1:0] function_o,
	input wire logic freeze_o,
	input wire logic write_gate_o
);
	default clocking cb @(posedge mclk_i); endclocking
	default disable iff (reset_i);
	// Decoded instructions; a frozen control must answer none but clear.
	logic is_skip;
	logic is_clr;
	logic is_rd;
	assign is_skip = iot_valid_i && iot_code_i == 18'h38E01;
	assign is_clr = iot_valid_i && iot_code_i == 18'h38E11;
	assign is_rd = iot_valid_i && iot_code_i == 18'h38E12;
	a_skip_on_flag: assert property (is_skip && disk_flag_o && !freeze_o |=> skip_o)
		else $error("skip missing with flag set");
	a_done_flag: assert property (status_o[10] |-> ##[0:1] disk_flag_o)
		else $error("complete bit without flag");
	a_err_summary: assert property (|status_o[7:1] |-> ##[0:1] status_o[0])
		else $error("error summary missing");
	a_flag_halts: assert property ($rose(disk_flag_o) |-> ##[0:1] function_o == 2'b00)
		else $error("function kept after flag");
	a_frozen_deaf: assert property (freeze_o && iot_valid_i && !is_clr
		|=> !skip_o && !ac_or_valid_o)
		else $error("frozen control answered");
	a_frozen_nowrite: assert property (freeze_o && $past(freeze_o) |-> !write_gate_o)
		else $error("writing while frozen");
	a_clear_unfreeze: assert property (is_clr && !timing_fault_evt_i && !addr_parity_evt_i
		|=> !freeze_o && function_o == 2'b00)
		else $error("clear did not release");
	a_pointer_answer: assert property (is_rd && !freeze_o |=> ac_or_valid_o)
		else $error("pointer read not answered");
	c_skip: cover property (skip_o);
	c_freeze: cover property (freeze_o);
	c_done: cover property (status_o[10]);
endmodule : disk_ctl_checker

bind disk_ctl disk_ctl_checker u_chk (.mclk_i(mclk_i), .reset_i(reset_i),
	.iot_valid_i(iot_valid_i), .iot_code_i(iot_code_i), .skip_o(skip_o),
	.timing_fault_evt_i(timing_fault_evt_i), .addr_parity_evt_i(addr_parity_evt_i),
	.ac_or_valid_o(ac_or_valid_o), .disk_flag_o(disk_flag_o), .status_o(status_o),
	.function_o(function_o), .freeze_o(freeze_o), .write_gate_o(write_gate_o));

// ---- disk_ctl_pkg.sv ----
/*
 * Types shared by the disk control modules.
 * Assumes disk_ctl_regs.svh supplies the numeric constants.
 */
package disk_ctl_pkg;
	// Function field of the function register.
	typedef enum logic [1:0] {
		FN_NONE = 2'b00,
		FN_READ = 2'b01,
		FN_WRITE = 2'b10,
		FN_CHECK = 2'b11
	} fn_e;

	// Transfer handshake phase.
	typedef enum logic [0:0] {
		XF_IDLE = 1'b0,
		XF_PENDING = 1'b1
	} xfer_e;
endpackage : disk_ctl_pkg

// ---- disk_ctl_regs.svh ----
/*
 * Constants of the fixed-head disk control: instruction codes, status bit
 * positions, field layouts and timing. Assumes an 18-bit processor whose
 * accumulator bit 0 is the most significant bit (ac[17]) and bit 17 the least (ac[0]).
 */
// What this block does
// - Address parity error sets bit 2 only while a function runs; it freezes.
// - Unserved transfer request for 130 ms sets missed-transfer bit 3.
// - Read advances address on request; write and check advance on acknowledge.
// - Write-check mismatch sets bit 4, raises error, stops checking.
// - Read word parity error sets bit 5, word still moves, transfers stop.
// - Write into protected region sets bit 6; read and check pass.
// - Absent drive selected or sequenced into sets bit 7 and error.
// - Channel late for next word sets warning bit 8, no error flag.
// - Only the first of address parity, data parity, lockout errors sets.
// - Illogical command sets warning bit 9; conflicting command is ignored.
// - Finished read, write or check job sets bit 10, interrupts, skips.
// - Code 707001 skips on disk flag, the OR of error and complete.
// - Code 707021 clears everything and unfreezes; frozen control obeys nothing else.
// - Code 707022 ORs track address and word address onto accumulator.
// - Code 707062 ORs drive number and overrun bit 14 onto accumulator.
// - Codes 707024 and 707064 load pointer and drive number from accumulator.
// - Code 707041 clears function register including interrupt enable.
// - Code 707042 XORs accumulator bits 15-17 into function register.
// - Code 707044 executes the held function from the current pointer.
// - Clear, XOR and execute may be combined in one instruction word.
// - Function bits 15-16 pick none, read, write, check; bit 17 enables interrupts.
// - Status bit 0 is OR of bits 1-7; interrupts, skips, halts operation.
// - Frozen control stops writing and inhibits timing pulses until cleared.
// - Posting the disk flag clears the executing function copy only.
`ifndef DISK_CTL_REGS_SVH
`define DISK_CTL_REGS_SVH

// Instruction word fields: group in [17:6], sub-device in [5:3], pulses in [2:0].
`define IOT_GROUP 12'hE38
`define SUB_FLAG 3'h0
`define SUB_POINTER 3'h2
`define SUB_FUNCTION 3'h4
`define SUB_DRIVE 3'h6
`define PULSE_1 0
`define PULSE_2 1
`define PULSE_4 2

// Status register bit positions, index equals printed bit number.
`define ST_ERR 0
`define ST_HDW 1
`define ST_APE 2
`define ST_MXF 3
`define ST_WCE 4
`define ST_DPE 5
`define ST_WLO 6
`define ST_NED 7
`define ST_DCH 8
`define ST_PGE 9
`define ST_XFC 10
`define STATUS_RESET 11'h000

// Pointer layout: track in accumulator bits 0-6, word in bits 7-17.
`define TRACK_MSB 17
`define TRACK_LSB 11
`define WORD_MSB 10
`define WORD_LSB 0
`define OVERRUN_BIT 3
`define POINTER_RESET 18'h00000
`define DRIVE_RESET 3'h0

// Missed-transfer timeout.
`define MXF_TIMEOUT_MS 130
`define MCLK_KHZ 25000

`endif

// ---- mxf_timer.sv ----
/*
 * One-shot timeout counter for an unserved transfer request.
 * Assumes start and stop are single-cycle requests from the control.
 */
`timescale 1ns/1ps
module mxf_timer import disk_ctl_pkg::*; #(
	parameter int CYCLES = 3250000
) (
	// Clock and reset.
	input wire logic mclk_i,
	input wire logic reset_i,
	// Control side.
	mxf_timer_if.tmr tif
);
	localparam int W = $clog2(CYCLES + 1);
	localparam logic [W-1:0] LAST = W'(CYCLES - 1);

	typedef struct packed {
		logic running;
		logic [W-1:0] count;
		logic expired;
	} tmr_s;

	tmr_s s;
	tmr_s next_s;

	// Restart wins over stop so a fresh request is always timed.
	always_comb begin
		next_s = s;
		next_s.expired = 1'b0;
		if (tif.start) begin
			next_s.running = 1'b1;
			next_s.count = '0;
		end else if (tif.stop) begin
			next_s.running = 1'b0;
		end else if (s.running) begin
			if (s.count == LAST) begin
				next_s.running = 1'b0;
				next_s.expired = 1'b1;
			end else begin
				next_s.count = s.count + W'(1);
			end
		end
	end

	// State register.
	always_ff @(posedge mclk_i) begin
		if (reset_i) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign tif.expired = s.expired;
endmodule : mxf_timer

// ---- mxf_timer_if.sv ----
/*
 * Carrier between the control and its missed-transfer timer.
 * Assumes both ends share one clock.
 */
`timescale 1ns/1ps
interface mxf_timer_if;
	logic start;
	logic stop;
	logic expired;
	modport ctrl (output start, output stop, input expired);
	modport tmr (input start, input stop, output expired);
endinterface : mxf_timer_if
